//--- src/dcc_pkg.sv
package dcc_pkg;

    // ----------------------------------------------------------------
    // Register map (index; byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_IRQ_ALLOW = 6'h08;
    localparam logic [5:0] IDX_PENDING = 6'h09;
    localparam logic [5:0] IDX_CTRL = 6'h12;
    localparam logic [5:0] IDX_LEVELS = 6'h13;
    localparam logic [5:0] IDX_STATUS = 6'h14;
    localparam logic [5:0] IDX_CLEAR = 6'h16;

    localparam logic [7:0] ADDR_IRQ_ALLOW = {IDX_IRQ_ALLOW, 2'b00};
    localparam logic [7:0] ADDR_PENDING = {IDX_PENDING, 2'b00};
    localparam logic [7:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] ADDR_LEVELS = {IDX_LEVELS, 2'b00};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [7:0] ADDR_CLEAR = {IDX_CLEAR, 2'b00};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PEND_LSB = 6;
    localparam int PEND_MSB = 7;
    localparam int STATUS_LSB = 0;
    localparam int STATUS_MSB = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] LEVELS_RST = 8'h00;
    localparam logic [1:0] PEND_RST = 2'h0;
    localparam logic [1:0] ALLOW_RST = 2'h0;

    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic irq_edge_select;
        logic internal_ref_enable;
        logic [1:0] on;
        logic [1:0] pin_drive;
        logic [1:0] ref_source;
    } dcc_ctrl_t;

    typedef struct packed {
        logic [3:0] cmp1_ref_level;
        logic [3:0] cmp0_ref_level;
    } dcc_levels_t;

endpackage // dcc_pkg

//--- src/dcc_top.sv
// Summary of operation
// - Shared edge bit picks rising or falling event
// - Bit six enables internal reference generator
// - Per-comparator enable bits turn comparators on
// - Drive bits put comparator result on pins
// - Source bit: one external, zero internal reference
// - Four-bit level code per comparator, fraction (n+2)/24
// - Status register returns synced outputs, read-only
// - Chosen output edge sets that comparator's pending flag
// - Writing zero clears pending flag, one keeps
// - Interrupt forwarded only while its allow bit set
module dcc_top (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // AXI4-Lite write address
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [dcc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    // AXI4-Lite write response
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    // AXI4-Lite read address
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [dcc_pkg::ADDR_W-1:0] i_s_axi_araddr,
    // AXI4-Lite read data
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    // Analog comparator cores
    input wire logic [1:0] i_cmp_raw_output,
    output logic [1:0] o_cmp_on,
    output logic [1:0] o_cmp_ref_source,
    output logic o_internal_ref_enable,
    output logic [3:0] o_cmp1_ref_level,
    output logic [3:0] o_cmp0_ref_level,
    // Comparator output pins
    output logic [1:0] o_cmp_pin,
    output logic [1:0] o_cmp_pin_oe,
    // Interrupt
    output logic o_irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    dcc_pkg::dcc_ctrl_t ctrl;
    dcc_pkg::dcc_levels_t levels;
    logic [1:0] pending;
    logic [1:0] irq_allow;
    logic [1:0] sync_a;
    logic [1:0] cmp_result;
    logic [1:0] result_prev;
    logic [1:0] pin_q;
    logic [1:0] pin_oe_q;

    // ----------------------------------------------------------------
    // Write channel holding
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [dcc_pkg::ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    wire aw_hs = i_s_axi_awvalid && !aw_held;
    wire w_hs = i_s_axi_wvalid && !w_held;
    // The response slot must be free, so one write is never lost to a stalled bready
    wire do_write = aw_held && w_held && !bvalid;
    wire wr_lane = do_write && w_lane0;
    wire wr_ctrl = wr_lane && aw_addr == dcc_pkg::ADDR_CTRL;
    wire wr_levels = wr_lane && aw_addr == dcc_pkg::ADDR_LEVELS;
    wire wr_pending = wr_lane && aw_addr == dcc_pkg::ADDR_PENDING;
    wire wr_allow = wr_lane && aw_addr == dcc_pkg::ADDR_IRQ_ALLOW;
    wire wr_clear = wr_lane && aw_addr == dcc_pkg::ADDR_CLEAR;
    wire aw_mapped = aw_addr == dcc_pkg::ADDR_CTRL || aw_addr == dcc_pkg::ADDR_LEVELS
        || aw_addr == dcc_pkg::ADDR_PENDING || aw_addr == dcc_pkg::ADDR_IRQ_ALLOW
        || aw_addr == dcc_pkg::ADDR_CLEAR || aw_addr == dcc_pkg::ADDR_STATUS;

    assign o_s_axi_awready = !aw_held;
    assign o_s_axi_wready = !w_held;
    assign o_s_axi_bvalid = bvalid;
    assign o_s_axi_bresp = bresp;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (aw_hs) begin
            aw_held <= 1'b1;
            aw_addr <= i_s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (w_hs) begin
            w_held <= 1'b1;
            w_byte <= i_s_axi_wdata[7:0];
            w_lane0 <= i_s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            bvalid <= 1'b0;
            bresp <= dcc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= aw_mapped ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_DECERR;
        end else if (i_s_axi_bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    wire ar_hs = i_s_axi_arvalid && !rvalid;
    wire rd_ctrl = i_s_axi_araddr == dcc_pkg::ADDR_CTRL;
    wire rd_levels = i_s_axi_araddr == dcc_pkg::ADDR_LEVELS;
    wire rd_status = i_s_axi_araddr == dcc_pkg::ADDR_STATUS;
    wire rd_pending = i_s_axi_araddr == dcc_pkg::ADDR_PENDING;
    wire rd_allow = i_s_axi_araddr == dcc_pkg::ADDR_IRQ_ALLOW;
    wire rd_clear = i_s_axi_araddr == dcc_pkg::ADDR_CLEAR;
    wire rd_mapped = rd_ctrl || rd_levels || rd_status || rd_pending || rd_allow || rd_clear;
    // status readback, read-only
    // The clear register is write-only and reads as zero
    wire [7:0] rd_byte = rd_ctrl ? ctrl
        : rd_levels ? levels
        : rd_status ? {6'h00, cmp_result}
        : rd_pending ? {pending, 6'h00}
        : rd_allow ? {irq_allow, 6'h00}
        : 8'h00;

    assign o_s_axi_arready = !rvalid;
    assign o_s_axi_rvalid = rvalid;
    assign o_s_axi_rdata = rdata;
    assign o_s_axi_rresp = rresp;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= dcc_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_mapped ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_DECERR;
        end else if (i_s_axi_rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // control fields stored
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl <= dcc_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= w_byte;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            levels <= dcc_pkg::LEVELS_RST;
        end else if (wr_levels) begin
            levels <= w_byte;
        end
    end

    assign o_internal_ref_enable = ctrl.internal_ref_enable;
    assign o_cmp_on = ctrl.on;
    assign o_cmp_ref_source = ctrl.ref_source;
    assign o_cmp1_ref_level = levels.cmp1_ref_level;
    assign o_cmp0_ref_level = levels.cmp0_ref_level;

    // ----------------------------------------------------------------
    // Synchroniser and edge detect
    // ----------------------------------------------------------------
    // two flops before any reader
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync_a <= 2'h0;
            cmp_result <= 2'h0;
            result_prev <= 2'h0;
        end else begin
            sync_a <= i_cmp_raw_output;
            cmp_result <= sync_a;
            result_prev <= cmp_result;
        end
    end

    wire [1:0] rise = cmp_result & ~result_prev;
    wire [1:0] fall = ~cmp_result & result_prev;
    wire [1:0] cmp_event = ctrl.irq_edge_select ? rise : fall;

    // pins driven only while enabled; low when withheld
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_q <= 2'h0;
            pin_oe_q <= 2'h0;
        end else begin
            pin_q <= cmp_result & ctrl.pin_drive;
            pin_oe_q <= ctrl.pin_drive;
        end
    end

    assign o_cmp_pin = pin_q;
    assign o_cmp_pin_oe = pin_oe_q;

    // ----------------------------------------------------------------
    // Interrupt flags
    // ----------------------------------------------------------------
    // write zero clears; clear register write one clears
    wire [1:0] clr_by_pend = wr_pending ? ~w_byte[dcc_pkg::PEND_MSB:dcc_pkg::PEND_LSB] : 2'h0;
    wire [1:0] clr_by_clear = wr_clear ? w_byte[dcc_pkg::PEND_MSB:dcc_pkg::PEND_LSB] : 2'h0;
    // a fresh event beats a clear in the same cycle
    wire [1:0] next_pending = cmp_event | (pending & ~(clr_by_pend | clr_by_clear));

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pending <= dcc_pkg::PEND_RST;
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            irq_allow <= dcc_pkg::ALLOW_RST;
        end else if (wr_allow) begin
            irq_allow <= w_byte[dcc_pkg::PEND_MSB:dcc_pkg::PEND_LSB];
        end
    end

    assign o_irq = |(pending & irq_allow);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence ctrl_wr_s;
        wr_ctrl;
    endsequence

    sequence status_rd_s;
        ar_hs && rd_status;
    endsequence

    rise_event_a: assert property (
        ctrl.irq_edge_select && rise[1] |=> pending[1])
        else $error("rising edge missed on comparator 1");

    fall_ignored_a: assert property (
        ctrl.irq_edge_select && fall[0] && !pending[0] |=> !pending[0])
        else $error("falling edge raised event in rising mode");

    ref_enable_a: assert property (
        ctrl_wr_s |=> o_internal_ref_enable == $past(w_byte[6]))
        else $error("reference enable does not follow write");

    cmp_on_a: assert property (
        ctrl_wr_s |=> o_cmp_on == $past(w_byte[5:4]))
        else $error("comparator enable does not follow write");

    pin_drive_a: assert property (
        ##1 o_cmp_pin == ($past(cmp_result) & $past(ctrl.pin_drive))
            && o_cmp_pin_oe == $past(ctrl.pin_drive))
        else $error("pin output not gated by drive bit");

    ref_source_a: assert property (
        ctrl_wr_s |=> o_cmp_ref_source == $past(w_byte[1:0]))
        else $error("reference source does not follow write");

    ref_level_a: assert property (
        wr_levels |=> {o_cmp1_ref_level, o_cmp0_ref_level} == $past(w_byte))
        else $error("reference level does not follow write");

    status_read_a: assert property (
        status_rd_s |=> o_s_axi_rdata == {30'h0, $past(cmp_result)})
        else $error("status read does not show result");

    fall_event_a: assert property (
        !ctrl.irq_edge_select && fall[0] |=> pending[0] ##1 (pending[0] || $past(wr_lane)))
        else $error("falling edge did not set pending flag");

    clear_zero_a: assert property (
        wr_pending && !w_byte[7] && !cmp_event[1] |=> !pending[1])
        else $error("write of zero did not clear flag");

    irq_gate_a: assert property (
        !irq_allow[1] && !irq_allow[0] |-> !o_irq)
        else $error("interrupt raised while not allowed");

    irq_pass_a: assert property (
        pending[1] && irq_allow[1] |-> o_irq)
        else $error("allowed pending flag did not raise interrupt");

    keep_one_a: assert property (
        wr_pending && w_byte[6] && pending[0] |=> pending[0])
        else $error("write of one cleared pending flag");

    sync_delay_a: assert property (
        $stable(i_cmp_raw_output) [*3] |-> cmp_result == $past(i_cmp_raw_output, 2))
        else $error("result not two flops behind input");

    resp_hold_a: assert property (
        o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped before bready");

endmodule // dcc_top

//--- testbench/dcc_cmp_model.sv
module dcc_cmp_model (
    // Control from the block
    input wire logic [1:0] i_on,
    input wire logic [1:0] i_ref_source,
    input wire logic i_ref_en,
    input wire logic [3:0] i_lvl1,
    input wire logic [3:0] i_lvl0,
    // Analog inputs in 24ths of supply
    input wire logic [1:0][4:0] i_pos,
    input wire logic [1:0][4:0] i_ext,
    // Raw comparator outputs
    output logic [1:0] o_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0][4:0] ladder;
    // ----------------------------------------
    // Reference ladder and cores
    // ----------------------------------------
    // Ladder off never trips
    assign ladder[1] = i_ref_en ? {1'b0, i_lvl1} + 5'h02 : 5'h1f;
    assign ladder[0] = i_ref_en ? {1'b0, i_lvl0} + 5'h02 : 5'h1f;
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            o_raw[k] = i_on[k] && (i_pos[k] > (i_ref_source[k] ? i_ext[k] : ladder[k]));
        end
    end
endmodule // dcc_cmp_model

//--- testbench/dcc_top_tb.sv
module dcc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq, ref_en;
    logic [1:0] bresp, rresp, raw, on, src, pin, pin_oe, resp;
    logic [31:0] rdata, data;
    logic [3:0] lvl1, lvl0;
    logic [1:0][4:0] pos = 10'h000;
    logic [1:0][4:0] ext = 10'h000;
    logic [7:0] cv [2] = '{8'h83, 8'h7c};
    int num_errors = 0;
    int compares = 0;

    dcc_top DUT (
        .i_mclk(mclk), .i_rst_n(rst_n),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_cmp_raw_output(raw),
        .o_cmp_on(on), .o_cmp_ref_source(src), .o_internal_ref_enable(ref_en),
        .o_cmp1_ref_level(lvl1), .o_cmp0_ref_level(lvl0), .o_cmp_pin(pin),
        .o_cmp_pin_oe(pin_oe), .o_irq(irq)
    );

    dcc_cmp_model cores (
        .i_on(on), .i_ref_source(src), .i_ref_en(ref_en), .i_lvl1(lvl1),
        .i_lvl0(lvl0), .i_pos(pos), .i_ext(ext), .o_raw(raw)
    );

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(name, data, exp);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rchk("ctrl rst", dcc_pkg::ADDR_CTRL, 32'h0);
        rchk("levels rst", dcc_pkg::ADDR_LEVELS, 32'h0);
        rchk("allow rst", dcc_pkg::ADDR_IRQ_ALLOW, 32'h0);
        foreach (cv[i]) begin
            wr(dcc_pkg::ADDR_CTRL, {24'h0, cv[i]});
            rchk("ctrl rb", dcc_pkg::ADDR_CTRL, {24'h0, cv[i]});
            chk("ref en", {31'h0, ref_en}, {31'h0, cv[i][6]});
            chk("on", {30'h0, on}, {30'h0, cv[i][5:4]});
            chk("pin oe", {30'h0, pin_oe}, {30'h0, cv[i][3:2]});
            chk("source", {30'h0, src}, {30'h0, cv[i][1:0]});
        end
        wr(dcc_pkg::ADDR_LEVELS, 32'h4a);
        chk("levels", {24'h0, lvl1, lvl0}, 32'h4a);
        // Falling mode: rising outputs must not raise events
        pos <= {5'h07, 5'h0d};
        repeat (5) @(posedge mclk);
        rchk("status hi", dcc_pkg::ADDR_STATUS, 32'h3);
        rchk("no rise evt", dcc_pkg::ADDR_PENDING, 32'h0);
        chk("pin", {30'h0, pin}, 32'h3);
        pos <= {5'h06, 5'h0b};
        repeat (5) @(posedge mclk);
        rchk("fall evt", dcc_pkg::ADDR_PENDING, 32'hc0);
        rchk("status lo", dcc_pkg::ADDR_STATUS, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(dcc_pkg::ADDR_IRQ_ALLOW, 32'h80);
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(dcc_pkg::ADDR_PENDING, 32'h40);
        rchk("clr zero", dcc_pkg::ADDR_PENDING, 32'h40);
        chk("irq off", {31'h0, irq}, 32'h0);
        wr(dcc_pkg::ADDR_IRQ_ALLOW, 32'h40);
        chk("irq cmp0", {31'h0, irq}, 32'h1);
        wr(dcc_pkg::ADDR_STATUS, 32'hff);
        chk("ro resp", {30'h0, resp}, {30'h0, dcc_pkg::RESP_OKAY});
        rchk("ro keep", dcc_pkg::ADDR_STATUS, 32'h0);
        wr(dcc_pkg::ADDR_CLEAR, 32'h40);
        rchk("clr reg", dcc_pkg::ADDR_PENDING, 32'h0);
        rchk("clr rd", dcc_pkg::ADDR_CLEAR, 32'h0);
        // Rising mode, comparator one on the outside reference
        ext <= {5'h14, 5'h00};
        wr(dcc_pkg::ADDR_CTRL, 32'hfe);
        pos <= {5'h15, 5'h0d};
        repeat (5) @(posedge mclk);
        rchk("rise evt", dcc_pkg::ADDR_PENDING, 32'hc0);
        rchk("ext ref", dcc_pkg::ADDR_STATUS, 32'h3);
        wr(dcc_pkg::ADDR_PENDING, 32'h0);
        repeat (8) @(posedge mclk);
        rchk("one evt", dcc_pkg::ADDR_PENDING, 32'h0);
        rd(8'h7c);
        chk("unmapped rd", {30'h0, resp}, {30'h0, dcc_pkg::RESP_DECERR});
        chk("unmapped data", data, 32'h0);
        wr(8'h7c, 32'hff);
        chk("unmapped wr", {30'h0, resp}, {30'h0, dcc_pkg::RESP_DECERR});
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule // dcc_top_tb
